// *** rtl/phy_regs_pkg.sv ***
// Constants for the line state and event interrupt register bank
package phy_regs_pkg;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_XOVER_CTRL = 6'h10;
  localparam logic [5:0] IDX_LINE_STATE = 6'h11;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
  localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h13;
  localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h14;
  localparam logic [5:0] IDX_SOFT_CTRL  = 6'h15;
  localparam int         ADDR_W         = 8;

  // Line state field positions
  localparam int LS_SPEED_LO = 14;
  localparam int LS_DUPLEX   = 13;
  localparam int LS_PAGE     = 12;
  localparam int LS_RESOLVED = 11;
  localparam int LS_LINK     = 10;
  localparam int LS_CROSS    = 6;
  localparam int LS_DOWNGR   = 5;
  localparam int LS_TX_PAUSE = 3;
  localparam int LS_RX_PAUSE = 2;
  localparam int LS_POLARITY = 1;
  localparam int LS_JABBER   = 0;

  // Event positions, shared by enable, flag and clear registers
  localparam int EV_NEG_FAULT = 15;
  localparam int EV_RATE      = 14;
  localparam int EV_DUPLEX    = 13;
  localparam int EV_PAGE      = 12;
  localparam int EV_LINK_FAIL = 11;
  localparam int EV_LINK_UP   = 10;
  localparam int EV_WAKE      = 6;
  localparam int EV_DOWNSHIFT = 5;
  localparam int EV_POLARITY  = 1;
  localparam int EV_BABBLE    = 0;

  // Crossover mode field and soft reset bit
  localparam int XO_MODE_LO  = 5;
  localparam int SOFT_RST_BIT = 0;

  // Reset values
  localparam logic [1:0]  XOVER_MODE_RST = 2'h3;
  localparam logic [15:0] IRQ_ENABLE_RST = 16'h0000;
  localparam logic [15:0] IRQ_FLAGS_RST  = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    XO_STRAIGHT = 2'b00,
    XO_CROSSED  = 2'b01,
    XO_RSVD     = 2'b10,
    XO_AUTO     = 2'b11
  } xover_mode_e;

endpackage : phy_regs_pkg

// *** rtl/phy_link_status_irq_enable_regs.sv ***
// Line state report and event interrupt registers behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module phy_link_status_irq_enable_regs
  import phy_regs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [1:0]        speed_in,
  input  wire logic              full_duplex_in,
  input  wire logic              link_up_in,
  input  wire logic              neg_enable_in,
  input  wire logic              neg_done_in,
  input  wire logic              page_rx_in,
  input  wire logic              auto_crossed_in,
  input  wire logic              downshift_in,
  input  wire logic              polarity_rev_in,
  input  wire logic              babble_in,
  input  wire logic              tx_pause_in,
  input  wire logic              rx_pause_in,
  input  wire logic              neg_fault_in,
  input  wire logic              wake_in,
  output logic [1:0]             xover_active,
  output logic                   irq
);

  logic [5:0]  aw_idx_r, aw_idx_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic [1:0]  ws_r, ws_nxt;
  logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [1:0]  mode_r, mode_nxt, applied_r, applied_nxt;
  logic [15:0] en_r, en_nxt, flags_r, flags_nxt;
  logic        page_r, page_nxt, irq_r, irq_nxt;
  logic [1:0]  spd_prev_r;
  logic        dup_prev_r, link_prev_r, dg_prev_r, pol_prev_r, jab_prev_r;
  logic [15:0] status_w, ev_w, wmask_w;
  logic        do_wr, ar_hs, st_rd, fl_rd, soft_rst;
  logic        cross_w, resolved_w;
  logic [5:0]  ar_idx;

  // Bus handshakes, withheld while ce freezes state so none is lost
  assign awready  = ce && !aw_full_r && !bvalid_r;
  assign wready   = ce && !w_full_r && !bvalid_r;
  assign arready  = ce && !rvalid_r;
  assign do_wr    = aw_full_r && w_full_r && !bvalid_r;
  assign ar_hs    = arvalid && arready;
  assign ar_idx   = araddr[7:2];
  assign st_rd    = ar_hs && (ar_idx == IDX_LINE_STATE);
  assign fl_rd    = ar_hs && (ar_idx == IDX_IRQ_FLAGS);
  assign wmask_w  = {{8{ws_r[1]}}, {8{ws_r[0]}}};
  assign soft_rst = do_wr && (aw_idx_r == IDX_SOFT_CTRL) && ws_r[0]
                    && wd_r[SOFT_RST_BIT];

  // Resolved line state as software sees it
  assign resolved_w = !neg_enable_in || neg_done_in;
  always_comb begin
    case (xover_mode_e'(applied_r))
      XO_AUTO:    cross_w = auto_crossed_in;
      XO_CROSSED: cross_w = 1'b1;
      default:    cross_w = 1'b0;
    endcase
  end
  always_comb begin
    status_w = 16'h0000;
    status_w[LS_SPEED_LO +: 2] = speed_in;
    status_w[LS_DUPLEX]   = full_duplex_in;
    status_w[LS_PAGE]     = page_r;
    status_w[LS_RESOLVED] = resolved_w;
    status_w[LS_LINK]     = link_up_in;
    status_w[LS_CROSS]    = cross_w && resolved_w;
    status_w[LS_DOWNGR]   = downshift_in;
    status_w[LS_TX_PAUSE] = tx_pause_in && neg_enable_in
                            && neg_done_in;
    status_w[LS_RX_PAUSE] = rx_pause_in && neg_enable_in
                            && neg_done_in;
    status_w[LS_POLARITY] = polarity_rev_in;
    status_w[LS_JABBER]   = babble_in;
  end

  // Raw interrupt causes
  always_comb begin
    ev_w = 16'h0000;
    ev_w[EV_NEG_FAULT] = neg_fault_in;
    ev_w[EV_RATE]      = speed_in != spd_prev_r;
    ev_w[EV_DUPLEX]    = full_duplex_in != dup_prev_r;
    ev_w[EV_PAGE]      = page_rx_in;
    ev_w[EV_LINK_FAIL] = link_prev_r && !link_up_in;
    ev_w[EV_LINK_UP]   = !link_prev_r && link_up_in;
    ev_w[EV_WAKE]      = wake_in;
    ev_w[EV_DOWNSHIFT] = downshift_in && !dg_prev_r;
    ev_w[EV_POLARITY]  = polarity_rev_in != pol_prev_r;
    ev_w[EV_BABBLE]    = babble_in && !jab_prev_r;
  end

  // Next state of bus channels and registers
  always_comb begin
    aw_idx_nxt  = aw_idx_r;
    wd_nxt      = wd_r;
    ws_nxt      = ws_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    mode_nxt    = mode_r;
    applied_nxt = applied_r;
    en_nxt      = en_r;
    if (awvalid && awready) begin
      aw_idx_nxt  = awaddr[7:2];
      aw_full_nxt = 1'b1;
    end
    if (wvalid && wready) begin
      wd_nxt     = wdata[15:0];
      ws_nxt     = wstrb[1:0];
      w_full_nxt = 1'b1;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // Write takes effect once address and data are both held
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case (aw_idx_r)
        IDX_XOVER_CTRL: begin
          if (ws_r[0]) begin
            mode_nxt = wd_r[XO_MODE_LO +: 2];
          end
        end
        IDX_IRQ_ENABLE: begin
          en_nxt = (en_r & ~wmask_w) | (wd_r & wmask_w);
        end
        IDX_LINE_STATE, IDX_IRQ_FLAGS, IDX_IRQ_CLEAR, IDX_SOFT_CTRL: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_DECERR;
        end
      endcase
    end
    if (soft_rst) begin
      applied_nxt = mode_r;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    // Read answer captured at the address handshake
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (ar_idx)
        IDX_XOVER_CTRL: rdata_nxt = {9'h000, mode_r, 5'h00};
        IDX_LINE_STATE: rdata_nxt = status_w;
        IDX_IRQ_ENABLE: rdata_nxt = en_r;
        IDX_IRQ_FLAGS:  rdata_nxt = flags_r;
        IDX_IRQ_CLEAR, IDX_SOFT_CTRL: rdata_nxt = 16'h0000;
        default: begin
          rdata_nxt = 16'h0000;
          rresp_nxt = RESP_DECERR;
        end
      endcase
    end
  end

  // Sticky flags and page latch, a new event wins over any clear
  always_comb begin
    flags_nxt = flags_r;
    page_nxt  = page_r;
    if (fl_rd || soft_rst) begin
      flags_nxt = 16'h0000;
    end
    if (do_wr && aw_idx_r == IDX_IRQ_CLEAR) begin
      flags_nxt = flags_nxt & ~(wd_r & wmask_w);
    end
    flags_nxt = flags_nxt | (ev_w & en_r);
    if (st_rd || soft_rst) begin
      page_nxt = 1'b0;
    end
    if (page_rx_in) begin
      page_nxt = 1'b1;
    end
    irq_nxt = |(flags_nxt & en_nxt);
  end

  // Register everything, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_idx_r    <= 6'h00;
      wd_r        <= 16'h0000;
      ws_r        <= 2'h0;
      aw_full_r   <= 1'b0;
      w_full_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= RESP_OKAY;
      rvalid_r    <= 1'b0;
      rresp_r     <= RESP_OKAY;
      rdata_r     <= 16'h0000;
      mode_r      <= XOVER_MODE_RST;
      applied_r   <= XOVER_MODE_RST;
      en_r        <= IRQ_ENABLE_RST;
      flags_r     <= IRQ_FLAGS_RST;
      page_r      <= 1'b0;
      irq_r       <= 1'b0;
      spd_prev_r  <= 2'h0;
      dup_prev_r  <= 1'b0;
      link_prev_r <= 1'b0;
      dg_prev_r   <= 1'b0;
      pol_prev_r  <= 1'b0;
      jab_prev_r  <= 1'b0;
    end else if (ce) begin
      aw_idx_r    <= aw_idx_nxt;
      wd_r        <= wd_nxt;
      ws_r        <= ws_nxt;
      aw_full_r   <= aw_full_nxt;
      w_full_r    <= w_full_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      mode_r      <= mode_nxt;
      applied_r   <= applied_nxt;
      en_r        <= en_nxt;
      flags_r     <= flags_nxt;
      page_r      <= page_nxt;
      irq_r       <= irq_nxt;
      spd_prev_r  <= speed_in;
      dup_prev_r  <= full_duplex_in;
      link_prev_r <= link_up_in;
      dg_prev_r   <= downshift_in;
      pol_prev_r  <= polarity_rev_in;
      jab_prev_r  <= babble_in;
    end
  end

  // Outputs
  assign bvalid       = bvalid_r && ce;                           // No answer while frozen
  assign bresp        = bresp_r;
  assign rvalid       = rvalid_r && ce;
  assign rresp        = rresp_r;
  assign rdata        = {16'h0000, rdata_r};
  assign xover_active = applied_r;
  assign irq          = irq_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_page_latch: assert property (ce && page_rx_in |=> page_r)
    else $error("page flag not latched");
  a_page_clear: assert property (
    ce && st_rd && !page_rx_in && page_r |=> !page_r)
    else $error("page flag not cleared by read");
  a_resolved_bit: assert property (
    ce && st_rd |=> rdata[LS_RESOLVED]
    == (!$past(neg_enable_in) || $past(neg_done_in)))
    else $error("resolution bit wrong");
  a_cross_gated: assert property (
    !status_w[LS_RESOLVED] |-> !status_w[LS_CROSS])
    else $error("crossover shown while unresolved");
  a_mode_apply: assert property (
    ce && soft_rst |=> applied_r == $past(mode_r))
    else $error("mode not applied at soft reset");
  a_pause_forced: assert property (
    !neg_enable_in |-> status_w[LS_TX_PAUSE:LS_RX_PAUSE] == 2'b00)
    else $error("pause shown in forced mode");
  a_fault_latch: assert property (
    ce && neg_fault_in && en_r[EV_NEG_FAULT] |=> flags_r[EV_NEG_FAULT])
    else $error("fault cause not latched");
  a_rate_latch: assert property (
    ce && speed_in != spd_prev_r && en_r[EV_RATE] |=> flags_r[EV_RATE])
    else $error("rate change not latched");
  a_link_fail: assert property (
    ce && link_prev_r && !link_up_in && en_r[EV_LINK_FAIL]
    |=> flags_r[EV_LINK_FAIL])
    else $error("link fail not latched");
  a_masked_quiet: assert property (
    ce && !fl_rd && !do_wr && (flags_r | (ev_w & en_r)) == 16'h0000
    |=> flags_r == 16'h0000 && !irq)
    else $error("flag set without enabled cause");
  a_flags_clear: assert property (
    ce && fl_rd && (ev_w & en_r) == 16'h0000 |=> flags_r == 16'h0000)
    else $error("flags not cleared by read");
  a_irq_level: assert property (irq == |(flags_r & en_r))
    else $error("interrupt level mismatch");

endmodule : phy_link_status_irq_enable_regs
`default_nettype wire

// *** bench/phy_link_status_irq_enable_regs_tb_top.sv ***
// Register bench for the line state and event interrupt register bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %h seen %h", nm, e, g); end end

module phy_link_status_irq_enable_regs_tb_top
  import phy_regs_pkg::*;
;
  logic              sys_clk, rst, ce;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, speed_in, xover_active;
  logic              arvalid, arready, rvalid, rready;
  logic              full_duplex_in, link_up_in, neg_enable_in, neg_done_in;
  logic              page_rx_in, auto_crossed_in, downshift_in;
  logic              polarity_rev_in, babble_in, tx_pause_in, rx_pause_in;
  logic              neg_fault_in, wake_in, irq;
  int                mismatches, cmp_count;
  int                ev_pos [10] = '{EV_NEG_FAULT, EV_RATE, EV_DUPLEX,
    EV_PAGE, EV_LINK_FAIL, EV_LINK_UP, EV_WAKE, EV_DOWNSHIFT, EV_POLARITY,
    EV_BABBLE};

  phy_link_status_irq_enable_regs dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .speed_in(speed_in), .full_duplex_in(full_duplex_in),
    .link_up_in(link_up_in), .neg_enable_in(neg_enable_in),
    .neg_done_in(neg_done_in), .page_rx_in(page_rx_in),
    .auto_crossed_in(auto_crossed_in), .downshift_in(downshift_in),
    .polarity_rev_in(polarity_rev_in), .babble_in(babble_in),
    .tx_pause_in(tx_pause_in), .rx_pause_in(rx_pause_in),
    .neg_fault_in(neg_fault_in), .wake_in(wake_in),
    .xover_active(xover_active), .irq(irq)
  );

  // Clock at 25 MHz
  always #20 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'h3;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    bready <= 1'b0;
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", er, bresp)
  endtask : wr

  // Bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    rready <= 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", {16'h0000, e}, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd

  // One event of the given position on the line inputs
  task automatic fire(input int p);
    @(posedge sys_clk);
    case (p)
      EV_NEG_FAULT: neg_fault_in <= 1'b1;
      EV_RATE:      speed_in <= speed_in ^ 2'b01;
      EV_DUPLEX:    full_duplex_in <= ~full_duplex_in;
      EV_PAGE:      page_rx_in <= 1'b1;
      EV_LINK_FAIL: link_up_in <= 1'b0;
      EV_LINK_UP:   link_up_in <= 1'b1;
      EV_WAKE:      wake_in <= 1'b1;
      EV_DOWNSHIFT: downshift_in <= 1'b0;
      EV_POLARITY:  polarity_rev_in <= ~polarity_rev_in;
      default:      babble_in <= 1'b0;
    endcase
    @(posedge sys_clk);
    neg_fault_in <= 1'b0;
    page_rx_in   <= 1'b0;
    wake_in      <= 1'b0;
    if (p == EV_DOWNSHIFT) downshift_in <= 1'b1;
    if (p == EV_BABBLE) babble_in <= 1'b1;
  endtask : fire

  // Watchdog against a hung handshake
  initial begin
    #(40 * 30000);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    {sys_clk, awaddr, araddr, awvalid, wvalid, bready, arvalid} = '0;
    {wdata, wstrb, rready, speed_in, full_duplex_in, link_up_in} = '0;
    {neg_enable_in, neg_done_in, page_rx_in, auto_crossed_in} = '0;
    {downshift_in, polarity_rev_in, babble_in, tx_pause_in} = '0;
    {rx_pause_in, neg_fault_in, wake_in} = '0;
    mismatches = 0;
    cmp_count  = 0;
    ce  = 1'b1;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values and readback of all enable bits
    `CHK("xover_active", 2'b11, xover_active)
    rd(8'h48, 16'h0000, RESP_OKAY);
    rd(8'h4c, 16'h0000, RESP_OKAY);
    rd(8'h40, 16'h0060, RESP_OKAY);
    wr(8'h48, 16'hffff, RESP_OKAY);
    rd(8'h48, 16'hffff, RESP_OKAY);
    wr(8'h48, 16'h0000, RESP_OKAY);
    // Line state encoding, negotiation in progress, done, disabled
    speed_in <= 2'b01;
    {full_duplex_in, link_up_in, downshift_in} <= 3'b111;
    {polarity_rev_in, babble_in, neg_enable_in} <= 3'b111;
    {tx_pause_in, rx_pause_in, auto_crossed_in} <= 3'b111;
    rd(8'h44, 16'h6423, RESP_OKAY);
    neg_done_in <= 1'b1;
    rd(8'h44, 16'h6c6f, RESP_OKAY);
    neg_enable_in <= 1'b0;
    rd(8'h44, 16'h6c63, RESP_OKAY);
    // Page latch holds until a status read
    fire(EV_PAGE);
    rd(8'h44, 16'h7c63, RESP_OKAY);
    rd(8'h44, 16'h6c63, RESP_OKAY);
    // Crossover mode takes effect only at soft reset
    auto_crossed_in <= 1'b0;
    wr(8'h40, 16'h0020, RESP_OKAY);
    rd(8'h44, 16'h6c23, RESP_OKAY);
    `CHK("xover_active", 2'b11, xover_active)
    wr(8'h54, 16'h0001, RESP_OKAY);
    `CHK("xover_active", 2'b01, xover_active)
    rd(8'h44, 16'h6c63, RESP_OKAY);
    rd(8'h40, 16'h0020, RESP_OKAY);
    wr(8'h40, 16'h0000, RESP_OKAY);
    wr(8'h54, 16'h0001, RESP_OKAY);
    `CHK("xover_active", 2'b00, xover_active)
    rd(8'h44, 16'h6c23, RESP_OKAY);
    // Reserved mode shows straight even with auto result crossed
    auto_crossed_in <= 1'b1;
    wr(8'h40, 16'h0040, RESP_OKAY);
    wr(8'h54, 16'h0001, RESP_OKAY);
    `CHK("xover_active", 2'b10, xover_active)
    rd(8'h44, 16'h6c23, RESP_OKAY);
    rd(8'h50, 16'h0000, RESP_OKAY);
    rd(8'h54, 16'h0000, RESP_OKAY);
    // Each event with only its own enable set
    foreach (ev_pos[i]) begin
      wr(8'h48, 16'h0001 << ev_pos[i], RESP_OKAY);
      fire(ev_pos[i]);
      repeat (3) @(posedge sys_clk);
      `CHK("irq", 1'b1, irq)
      rd(8'h4c, 16'h0001 << ev_pos[i], RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      `CHK("irq", 1'b0, irq)
    end
    // Masked event leaves no flag
    wr(8'h48, 16'h7fff, RESP_OKAY);
    fire(EV_NEG_FAULT);
    repeat (3) @(posedge sys_clk);
    `CHK("irq", 1'b0, irq)
    rd(8'h4c, 16'h0000, RESP_OKAY);
    // Clear register drops a flag and the interrupt
    wr(8'h48, 16'h8000, RESP_OKAY);
    fire(EV_NEG_FAULT);
    @(posedge sys_clk);
    `CHK("irq", 1'b1, irq)
    wr(8'h50, 16'h8000, RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'b0, irq)
    rd(8'h4c, 16'h0000, RESP_OKAY);
    // Unmapped address
    rd(8'h7c, 16'h0000, RESP_DECERR);
    wr(8'h7c, 16'hffff, RESP_DECERR);
    rd(8'h48, 16'h8000, RESP_OKAY);
    // Clock enable low freezes state, an event then leaves no flag
    ce <= 1'b0;
    fire(EV_NEG_FAULT);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'b0, irq)
    ce <= 1'b1;
    rd(8'h4c, 16'h0000, RESP_OKAY);
    // Second reset in mid-run restores mode and enables
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    `CHK("xover_active", 2'b11, xover_active)
    rd(8'h48, 16'h0000, RESP_OKAY);
    rd(8'h40, 16'h0060, RESP_OKAY);
    close_out();
  end
endmodule : phy_link_status_irq_enable_regs_tb_top

`default_nettype wire
